// ==== logic/xbs_mux.sv ====
// Module: X-bus chip select decode and shared IDE data pin mux
`timescale 1ns/1ps

module xbs_mux
    import xbs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Bus cycle and ownership
    input wire xbs_cycle_t cycle_i,
    input wire logic isa_active_i,
    // IDE side data, upper nibble
    input wire logic [3:0] ide_dd_out_i,
    input wire logic ide_dd_drive_i,
    input wire logic [3:0] dd_hi_i,
    output logic [3:0] ide_dd_in_o,
    // Shared pins, 15 down to 12
    output logic [3:0] dd_hi_o,
    output logic [3:0] dd_hi_oe_o,
    // Dedicated outputs
    output logic rtc_addr_strobe_o,
    output logic transceiver_out_enable_n_o
);

    // ****************************************
    // Decode helpers
    // ****************************************
    // Port match under a mask; a zero mask bit is a don't-care
    function automatic logic io_hit(input logic [15:0] a, input logic [15:0] port, input logic [15:0] mask);
        io_hit = ((a & mask) == (port & mask));
    endfunction

    // Single port match, every port bit compared
    function automatic logic exact_hit(input logic [15:0] a, input logic [15:0] port);
        exact_hit = io_hit(a, port, XBS_PORT_EXACT);
    endfunction

    // ROM window match on the full memory address
    function automatic logic rom_hit(input logic [23:0] a);
        rom_hit = ((a & XBS_ROM_MASK) == XBS_ROM_BASE);
    endfunction

    // ****************************************
    // Command qualifiers
    // ****************************************
    logic [15:0] port_addr;
    logic mem_cyc;
    logic io_rd;
    logic io_wr;
    logic io_cyc;

    // I/O targets decode the 16 port bits only, as on the ISA bus
    assign port_addr = cycle_i.addr[15:0];
    assign mem_cyc = ~cycle_i.mem_rd_n | ~cycle_i.mem_wr_n;
    assign io_rd = ~cycle_i.io_rd_n;
    assign io_wr = ~cycle_i.io_wr_n;
    assign io_cyc = io_rd | io_wr;

    // ****************************************
    // Target classification
    // ****************************************
    // One target per cycle; a miss falls to none and strobes nothing
    typedef enum logic [4:0] {
        XBS_TGT_NONE = 5'b00001,
        XBS_TGT_ROM = 5'b00010,
        XBS_TGT_RTC_INDEX = 5'b00100,
        XBS_TGT_RTC_DATA = 5'b01000,
        XBS_TGT_KBD = 5'b10000
    } xbs_target_t;

    xbs_target_t target;

    always_comb begin
        // Priority only matters for an illegal mix of memory and I/O commands
        target = XBS_TGT_NONE;
        if (mem_cyc && rom_hit(cycle_i.addr)) begin
            target = XBS_TGT_ROM;
        end else if (io_cyc && exact_hit(port_addr, XBS_RTC_INDEX_PORT)) begin
            target = XBS_TGT_RTC_INDEX;
        end else if (io_cyc && exact_hit(port_addr, XBS_RTC_DATA_PORT)) begin
            target = XBS_TGT_RTC_DATA;
        end else if (io_cyc && (exact_hit(port_addr, XBS_KBD_PORT_LO)
                || exact_hit(port_addr, XBS_KBD_PORT_HI))) begin
            target = XBS_TGT_KBD;
        end
    end

    // ****************************************
    // Next select values
    // ****************************************
    xbs_sel_t sel_next;
    logic as_next;

    always_comb begin
        // Default deasserted so a miss never strobes anything
        sel_next = '{XBS_SEL_IDLE_N, XBS_SEL_IDLE_N, XBS_SEL_IDLE_N, XBS_SEL_IDLE_N};
        case (target)
            XBS_TGT_ROM: begin
                sel_next.rom_rtc_select_n = 1'b0;
            end
            XBS_TGT_RTC_INDEX: begin
                sel_next.rom_rtc_select_n = 1'b0;
            end
            XBS_TGT_RTC_DATA: begin
                sel_next.rom_rtc_select_n = 1'b0;
                // Strobes follow the command alone, whatever the data value
                sel_next.rtc_write_strobe_n = ~io_wr;
                sel_next.rtc_read_strobe_n = ~io_rd;
            end
            XBS_TGT_KBD: begin
                sel_next.keyboard_select_n = 1'b0;
            end
            default: begin
                sel_next.rom_rtc_select_n = XBS_SEL_IDLE_N;
            end
        endcase
    end

    always_comb begin
        as_next = XBS_AS_IDLE;
        case (target)
            XBS_TGT_RTC_INDEX: begin
                as_next = io_wr;
            end
            default: begin
                as_next = XBS_AS_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registered selects and strobe
    // ****************************************
    xbs_sel_t sel_reg;
    logic as_reg;
    logic oe_n_reg;
    logic [3:0] dd_reg;

    // Registered so the pins never glitch while the address settles
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sel_reg <= '{XBS_SEL_IDLE_N, XBS_SEL_IDLE_N, XBS_SEL_IDLE_N, XBS_SEL_IDLE_N};
        end else begin
            sel_reg <= sel_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            as_reg <= XBS_AS_IDLE;
        end else begin
            as_reg <= as_next;
        end
    end

    // ****************************************
    // Pin function and IDE data
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            oe_n_reg <= XBS_OE_N_IDLE;
        end else begin
            // Same edge as the selects so pin function and select change together
            oe_n_reg <= ~isa_active_i;
        end
    end

    // Registered like the selects so both pin functions leave from flops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dd_reg <= XBS_DD_RESET;
        end else begin
            dd_reg <= ide_dd_out_i;
        end
    end

    // ****************************************
    // Shared pin mux
    // ****************************************
    // Selects idle high; external OR with output enable keeps the chip selects high in IDE mode
    logic [3:0] sel_pins;
    logic isa_mode;

    // Struct order matches pin order: bit 3 is pin 15
    assign sel_pins = sel_reg;
    assign isa_mode = ~oe_n_reg;

    for (genvar i = 0; i < XBS_SHARED_PINS; i++) begin : g_pin
        assign dd_hi_o[i] = isa_mode ? sel_pins[i] : dd_reg[i];
        // Pads never float in ISA mode; in IDE mode the IDE side decides
        assign dd_hi_oe_o[i] = isa_mode | ide_dd_drive_i;
    end

    // ****************************************
    // Input path
    // ****************************************
    // A plain wire; pad sampling is left to the IDE side
    assign ide_dd_in_o = dd_hi_i;

    // ****************************************
    // Dedicated outputs
    // ****************************************
    assign rtc_addr_strobe_o = as_reg;
    assign transceiver_out_enable_n_o = oe_n_reg;

endmodule // xbs_mux

// ==== logic/xbs_pkg.sv ====
// Package: constants and carrier types for the X-bus select / IDE data mux
package xbs_pkg;

    // ****************************************
    // Address decode constants
    // ****************************************
    localparam logic [15:0] XBS_RTC_INDEX_PORT = 16'h0070;
    localparam logic [15:0] XBS_RTC_DATA_PORT = 16'h0071;
    localparam logic [15:0] XBS_KBD_PORT_LO = 16'h0060;
    localparam logic [15:0] XBS_KBD_PORT_HI = 16'h0064;
    localparam logic [15:0] XBS_KBD_PORT_MASK = 16'hfffb;
    localparam logic [15:0] XBS_RTC_PORT_MASK = 16'hfffe;
    localparam logic [15:0] XBS_PORT_EXACT = 16'hffff;
    localparam int XBS_SHARED_PINS = 4;
    localparam logic [23:0] XBS_ROM_BASE = 24'h0f0000;
    localparam logic [23:0] XBS_ROM_MASK = 24'hff0000;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic XBS_SEL_IDLE_N = 1'b1;
    localparam logic XBS_AS_IDLE = 1'b0;
    localparam logic [3:0] XBS_DD_RESET = 4'h0;
    localparam logic XBS_OE_N_IDLE = 1'b1;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [23:0] addr;
        logic mem_rd_n;
        logic mem_wr_n;
        logic io_rd_n;
        logic io_wr_n;
    } xbs_cycle_t;

    typedef struct packed {
        logic rom_rtc_select_n;
        logic keyboard_select_n;
        logic rtc_write_strobe_n;
        logic rtc_read_strobe_n;
    } xbs_sel_t;

endpackage

// ==== sim/test_xbs_mux.sv ====
// Testbench: decode and pin sharing of the select mux
`timescale 1ns/1ps
module test_xbs_mux;
    import xbs_pkg::*;
    logic clk_i = 0, srst_i = 1, isa = 0, drv = 0, as_o, oe_n;
    xbs_cycle_t cyc = {24'h0, 4'hf};
    logic [3:0] pins, oe, pin_wire, din;
    logic [3:0] dd = 4'ha;
    logic [2:0] chips;
    int err_total = 0, n_tests = 0, cnt = 0;
    // Released lines show the inverse of the last driven value
    assign pin_wire = oe == 4'hf ? pins : ~pins;
    xbs_mux xbs_mux_inst (.clk_i(clk_i), .srst_i(srst_i), .cycle_i(cyc), .isa_active_i(isa),
        .ide_dd_out_i(dd), .ide_dd_drive_i(drv), .dd_hi_i(pin_wire), .ide_dd_in_o(din), .dd_hi_o(pins),
        .dd_hi_oe_o(oe), .rtc_addr_strobe_o(as_o), .transceiver_out_enable_n_o(oe_n));
    xbs_far_side xbs_far_side_inst (.cycle_i(cyc), .pins_i(pins), .oe_n_i(oe_n), .chip_o(chips));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [23:0] a, input logic [3:0] c, input logic m, input logic s,
        input logic [3:0] p, input logic [2:0] k);
        @(posedge clk_i);
        cyc <= {a, c};
        isa <= m;
        drv <= m;
        @(posedge clk_i);
        #1;
        chk({oe_n, as_o, oe, pins, chips, din}, {~m, s, {4{m}}, m ? p : dd, k, m ? p : ~dd});
    endtask
    task automatic t_drive();
        @(posedge clk_i);
        drv <= 1;
        dd <= 4'h3;
        @(posedge clk_i);
        #1;
        chk({oe_n, as_o, oe, pins, chips, din}, {1'b1, 1'b1, 4'hf, 4'h3, 3'b001, 4'h3});
        $display("drive done");
    endtask
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_rtc();
        run(24'h70, 4'he, 1, 1, 4'h7, 3'b011);
        run(24'h71, 4'he, 1, 0, 4'h5, 3'b011);
        run(24'h71, 4'hd, 1, 0, 4'h6, 3'b011);
        $display("rtc done");
    endtask
    task automatic t_sel();
        run(24'h60, 4'hd, 1, 0, 4'hb, 3'b000);
        run(24'h64, 4'he, 1, 0, 4'hb, 3'b000);
        run(24'h0f0000, 4'h7, 1, 0, 4'h7, 3'b101);
        run(24'h0fffff, 4'hb, 1, 0, 4'h7, 3'b101);
        $display("select done");
    endtask
    task automatic t_miss();
        run(24'h72, 4'hd, 1, 0, 4'hf, 3'b001);
        run(24'h1f0000, 4'h7, 1, 0, 4'hf, 3'b001);
        run(24'h70, 4'hf, 1, 0, 4'hf, 3'b001);
        $display("miss done");
    endtask
    task automatic t_ide();
        run(24'h71, 4'he, 0, 0, 4'h0, 3'b001);
        run(24'h0f0000, 4'h7, 0, 0, 4'h0, 3'b001);
        run(24'h60, 4'hd, 0, 0, 4'h0, 3'b001);
        run(24'h70, 4'he, 0, 1, 4'h0, 3'b001);
        $display("ide done");
    endtask
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        if (cnt == 400) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 0;
        t_rtc();
        t_sel();
        t_miss();
        t_ide();
        t_drive();
        conclude();
    end
endmodule // test_xbs_mux

// ==== sim/xbs_far_side.sv ====
// Far side: ROM, RTC and keyboard behind the external OR buffer
`timescale 1ns/1ps
module xbs_far_side import xbs_pkg::*; (
    input wire xbs_cycle_t cycle_i,
    input wire logic [3:0] pins_i,
    input wire logic oe_n_i,
    output logic [2:0] chip_o
);
    logic [3:0] gated;
    // OR with the output enable holds selects high while the buffer is off
    assign gated = pins_i | {4{oe_n_i}};
    assign chip_o = {!gated[3] && !(cycle_i.mem_rd_n && cycle_i.mem_wr_n),
        !gated[3] && !(cycle_i.io_rd_n && cycle_i.io_wr_n), gated[2]};
endmodule // xbs_far_side

// ==== sim/xbs_mux_asserts.sv ====
// Checker: port properties of the select mux
`timescale 1ns/1ps
module xbs_mux_asserts import xbs_pkg::*; (
    input wire logic clk_i, input wire logic srst_i, input wire xbs_cycle_t cycle_i,
    input wire logic isa_active_i, input wire logic ide_dd_drive_i, input wire logic [3:0] dd_hi_o,
    input wire logic [3:0] ide_dd_out_i,
    input wire logic [3:0] dd_hi_oe_o, input wire logic rtc_addr_strobe_o, input wire logic transceiver_out_enable_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_as; !cycle_i.io_wr_n && cycle_i.addr == 24'h70 |=> rtc_addr_strobe_o; endproperty
    a_as: assert property (p_as) else $error("address strobe missing");
    property p_wr; isa_active_i && !cycle_i.io_wr_n && cycle_i.addr == 24'h71 |=> !dd_hi_o[1]; endproperty
    a_wr: assert property (p_wr) else $error("write strobe missing");
    property p_rd; isa_active_i && !cycle_i.io_rd_n && cycle_i.addr == 24'h71 |=> dd_hi_o[3] == 1'b0 && !dd_hi_o[0]; endproperty
    a_rd: assert property (p_rd) else $error("read strobe missing");
    property p_kb; isa_active_i && !cycle_i.io_rd_n && cycle_i.addr == 24'h60 |=> !dd_hi_o[2]; endproperty
    a_kb: assert property (p_kb) else $error("keyboard select missing");
    property p_rom; isa_active_i && !cycle_i.mem_rd_n && cycle_i.addr[23:16] == 8'h0f |=> !dd_hi_o[3]; endproperty
    a_rom: assert property (p_rom) else $error("rom select missing");
    property p_idle; isa_active_i && cycle_i[3:0] == 4'hf |=> dd_hi_o == 4'hf && !rtc_addr_strobe_o; endproperty
    a_idle: assert property (p_idle) else $error("select without cycle");
    property p_oen; isa_active_i |=> !transceiver_out_enable_n_o; endproperty
    a_oen: assert property (p_oen) else $error("enable not low");
    property p_oef; !isa_active_i |=> transceiver_out_enable_n_o; endproperty
    a_oef: assert property (p_oef) else $error("enable not high");
    property p_dd; transceiver_out_enable_n_o && !$past(srst_i) |-> dd_hi_o == $past(ide_dd_out_i); endproperty
    a_dd: assert property (p_dd) else $error("ide data not on pins");
    property p_ide; transceiver_out_enable_n_o |-> dd_hi_oe_o == {4{ide_dd_drive_i}}; endproperty
    a_ide: assert property (p_ide) else $error("ide drive wrong");
    property p_isa; !transceiver_out_enable_n_o |-> dd_hi_oe_o == 4'hf; endproperty
    a_isa: assert property (p_isa) else $error("isa drive wrong");
    c_as: cover property (rtc_addr_strobe_o);
    c_rom: cover property (!dd_hi_o[3] && !transceiver_out_enable_n_o);
    c_ide: cover property (transceiver_out_enable_n_o && !ide_dd_drive_i);
endmodule // xbs_mux_asserts
bind xbs_mux xbs_mux_asserts xbs_mux_asserts_inst (.*);
